// ==== src/tlv_irq_ctrl.sv ====
/*
  Two-level vectored interrupt controller with an AHB-Lite register slave.
  Assumes the CPU pulses instr_done_i in the last cycle of each instruction,
  with return_from_service_i qualifying a retiring return instruction.
*/
// Notes on behaviour
// [RL1] Requests sampled and resolved every clock.
// [RL2] Best case: one detect, four call cycles.
// [RL3] After return, one instruction completes before call.
// [RL4] Worst case eighteen clocks from CPU timing.
// [RL5] Equal or higher routine holds new requests off.
// [RL6] Vectors from 0x0003 stepping eight bytes.
// [RL7] Same level ties go by fixed order.
// [RL8] Externals and timers zero/one cleared on vectoring.
// [RL9] SPI request ORs its four flags.
// [RL10] Counter array ORs all its flags.
// [RL11] Global gate bit seven blocks everything.
// [RL12] Low seven enable bits mask the sources.
// [RL13] Timer two uses either overflow flag.
// [RL14] Flags set regardless; software set requests too.
// [RL15] High preempts low; nothing preempts high.
// [RL16] Flag still set after return re-requests.
// [RL17] Extended enable masks seven sources, resets zero.
// [RL18] Vector only pending, enabled, gated sources.
`timescale 1ns/1ps
`default_nettype none

module tlv_irq_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Condition pulses for flags kept here
  input wire logic ext_request_pin_zero_i,
  input wire logic ext_request_pin_one_i,
  input wire logic timer_zero_overflow_flag_i,
  input wire logic timer_one_overflow_flag_i,
  // Peripheral-held flag levels
  input wire logic uart_rx_flag_i,
  input wire logic uart_tx_flag_i,
  input wire logic timer_two_high_overflow_i,
  input wire logic timer_two_low_overflow_i,
  input wire logic serial_xfer_done_flag_i,
  input wire logic write_collision_flag_i,
  input wire logic mode_fault_flag_i,
  input wire logic receive_overrun_flag_i,
  input wire logic smbus_flag_i,
  input wire logic port_match_i,
  input wire logic window_compare_flag_i,
  input wire logic conversion_done_flag_i,
  input wire logic counter_array_overflow_i,
  input wire logic [2:0] module_match_flag_i,
  input wire logic pwm_counter_overflow_i,
  input wire logic comparator_fall_flag_i,
  input wire logic comparator_rise_flag_i,
  input wire logic timer_three_high_overflow_i,
  input wire logic timer_three_low_overflow_i,
  // CPU side
  input wire logic instr_done_i,
  input wire logic return_from_service_i,
  output logic call_active_o,
  output logic [15:0] vector_o,
  output logic vector_taken_o,
  output logic [1:0] in_service_o,
  // Interrupt to system
  output logic irq_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] enable;
    logic [6:0] level;
    logic [7:0] ext_enable;
    logic [7:0] ext_level;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    tlv_pkg::tlv_seq_t seq;
    logic [2:0] cnt;
    logic [3:0] call_idx;
    logic call_hi;
    logic hi_act;
    logic lo_act;
    logic [15:0] vector;
    logic [31:0] rdata;
    logic dp_wr;
    logic [11:0] dp_addr;
    logic cand_valid;
    logic [3:0] cand_idx;
    logic cand_hi;
  } tlv_ctrl_state_t;

  tlv_ctrl_state_t st_reg;
  tlv_ctrl_state_t st_next;

  // Spreads a 7-bit base and an 8-bit extension register over the fifteen slots.
  function automatic logic [14:0] spread(input logic [6:0] base, input logic [7:0] ext);
    return {ext[7], 1'b0, ext[5:0], base};
  endfunction

  // ----------------------------------------------------------------------
  // Pending flags and requests
  // ----------------------------------------------------------------------
  logic addr_phase;
  logic wr_en;
  logic [14:0] pend_set;
  logic [14:0] pend_clr;
  logic [14:0] hw_clr;
  logic [14:0] local_flags;
  logic [14:0] hw_levels;
  logic [14:0] pending;
  logic [14:0] src_en;
  logic [14:0] src_hi;
  logic [14:0] req;
  logic arb_valid;
  logic [3:0] arb_idx;
  logic arb_hi;
  logic allowed;
  logic take;
  logic done_call;
  logic return_from_service_now;

  // Bus write decode for the data phase.
  always_comb
  begin
    addr_phase = hsel_i && htrans_i[1] && hready_i;
    wr_en = st_reg.dp_wr;
    pend_set = (wr_en && st_reg.dp_addr == tlv_pkg::PEND_SET_ADDR) ? hwdata_i[14:0] : '0;
    pend_clr = (wr_en && st_reg.dp_addr == tlv_pkg::PEND_ADDR) ? hwdata_i[14:0] : '0;
  end

  // Peripheral flags combine into one request per vector.
  always_comb
  begin
    hw_levels = '0;
    hw_levels[4] = uart_rx_flag_i | uart_tx_flag_i;
    hw_levels[5] = timer_two_high_overflow_i | timer_two_low_overflow_i; // see [RL13]
    hw_levels[6] = serial_xfer_done_flag_i | write_collision_flag_i
                 | mode_fault_flag_i | receive_overrun_flag_i; // see [RL9]
    hw_levels[7] = smbus_flag_i;
    hw_levels[8] = port_match_i;
    hw_levels[9] = window_compare_flag_i;
    hw_levels[10] = conversion_done_flag_i;
    hw_levels[11] = counter_array_overflow_i | (|module_match_flag_i)
                  | pwm_counter_overflow_i; // see [RL10]
    hw_levels[12] = comparator_fall_flag_i | comparator_rise_flag_i;
    hw_levels[14] = timer_three_high_overflow_i | timer_three_low_overflow_i;
  end

  // Auto-cleared flags drop in the last call cycle.
  assign hw_clr = done_call ? (tlv_pkg::AUTO_CLR_MASK & (15'h0001 << st_reg.call_idx)) : '0; // see [RL8]

  tlv_flag_bank u_flags (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .hw_set_i({11'h000, timer_one_overflow_flag_i, ext_request_pin_one_i,
               timer_zero_overflow_flag_i, ext_request_pin_zero_i}),
    .sw_set_i(pend_set),
    .sw_clr_i(pend_clr),
    .hw_clr_i(hw_clr),
    .flags_o(local_flags)
  );

  // Flags set whatever the enables; a flag left set keeps requesting.
  always_comb
  begin
    pending = (local_flags | hw_levels) & tlv_pkg::IMPL_MASK; // see [RL14] see [RL16]
    src_en = spread(st_reg.enable[6:0], st_reg.ext_enable); // see [RL12] see [RL17]
    src_hi = spread(st_reg.level, st_reg.ext_level);
    req = pending & src_en & {15{st_reg.enable[tlv_pkg::GATE_BIT]}}; // see [RL11] see [RL18]
  end

  tlv_arbiter u_arb (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .req_i(req),
    .hi_i(src_hi),
    .valid_o(arb_valid),
    .idx_o(arb_idx),
    .hi_o(arb_hi)
  );

  // ----------------------------------------------------------------------
  // Call sequencer
  // ----------------------------------------------------------------------
  // A call starts at an instruction boundary that is not a return.
  always_comb
  begin
    return_from_service_now = instr_done_i && return_from_service_i;
    allowed = st_reg.cand_valid && req[st_reg.cand_idx]
            && (st_reg.cand_hi ? !st_reg.hi_act : !(st_reg.hi_act || st_reg.lo_act)); // see [RL5]
    take = (st_reg.seq == tlv_pkg::ST_IDLE) && instr_done_i && !return_from_service_i
         && allowed; // see [RL3] see [RL4]
    done_call = (st_reg.seq == tlv_pkg::ST_CALL) && (st_reg.cnt == tlv_pkg::CALL_CYCLES);
  end

  // Next state of sequencer, registers and bus slave.
  always_comb
  begin
    st_next = st_reg;
    st_next.cand_valid = arb_valid; // see [RL1]
    st_next.cand_idx = arb_idx;
    st_next.cand_hi = arb_hi;
    unique case (st_reg.seq)
      tlv_pkg::ST_IDLE:
      begin
        if (take)
        begin
          st_next.seq = tlv_pkg::ST_CALL;
          st_next.cnt = 3'h1;
          st_next.call_idx = st_reg.cand_idx;
          st_next.call_hi = st_reg.cand_hi;
          st_next.vector = tlv_pkg::VEC_BASE
                         + {9'h000, st_reg.cand_idx, 3'h0}; // see [RL6]
        end
        else if (return_from_service_now)
        begin
          if (st_reg.hi_act)
            st_next.hi_act = 1'b0;
          else
            st_next.lo_act = 1'b0;
        end
      end
      tlv_pkg::ST_CALL:
      begin
        st_next.cnt = st_reg.cnt + 3'h1; // see [RL2]
        if (done_call)
        begin
          st_next.seq = tlv_pkg::ST_IDLE;
          st_next.cnt = 3'h0;
          if (st_reg.call_hi)
            st_next.hi_act = 1'b1;
          else
            st_next.lo_act = 1'b1;
        end
      end
    endcase
    // Events set sticky status; a write of one clears, a new event wins.
    if (wr_en && st_reg.dp_addr == tlv_pkg::IRQ_STAT_ADDR)
      st_next.irq_stat = st_reg.irq_stat & ~hwdata_i[1:0];
    if (done_call)
      st_next.irq_stat[tlv_pkg::EVT_VECTORED] = 1'b1;
    if (take && st_reg.cand_hi && st_reg.lo_act)
      st_next.irq_stat[tlv_pkg::EVT_PREEMPT] = 1'b1;
    // Data phase writes.
    if (wr_en)
    begin
      unique case (st_reg.dp_addr)
        tlv_pkg::ENABLE_ADDR: st_next.enable = hwdata_i[7:0];
        tlv_pkg::LEVEL_ADDR: st_next.level = hwdata_i[6:0];
        tlv_pkg::EXT_ENABLE_ADDR: st_next.ext_enable = hwdata_i[7:0] & 8'hbf;
        tlv_pkg::EXT_LEVEL_ADDR: st_next.ext_level = hwdata_i[7:0] & 8'hbf;
        tlv_pkg::IRQ_MASK_ADDR: st_next.irq_mask = hwdata_i[1:0];
        default: st_next.irq_mask = st_reg.irq_mask;
      endcase
    end
    // Address phase: latch write target, or fetch read data now.
    st_next.dp_wr = addr_phase && hwrite_i;
    if (addr_phase)
      st_next.dp_addr = haddr_i[11:0];
    if (addr_phase && !hwrite_i)
    begin
      unique case (haddr_i[11:0])
        tlv_pkg::ENABLE_ADDR: st_next.rdata = {24'h0, st_reg.enable};
        tlv_pkg::LEVEL_ADDR: st_next.rdata = {24'h0, 1'b1, st_reg.level};
        tlv_pkg::EXT_ENABLE_ADDR: st_next.rdata = {24'h0, st_reg.ext_enable};
        tlv_pkg::EXT_LEVEL_ADDR: st_next.rdata = {24'h0, st_reg.ext_level};
        tlv_pkg::PEND_ADDR: st_next.rdata = {17'h0, pending};
        tlv_pkg::IRQ_STAT_ADDR: st_next.rdata = {30'h0, st_reg.irq_stat};
        tlv_pkg::IRQ_MASK_ADDR: st_next.rdata = {30'h0, st_reg.irq_mask};
        tlv_pkg::STATE_ADDR: st_next.rdata = {16'h0, st_reg.cand_valid, st_reg.cand_hi,
                                             st_reg.cand_idx, 4'h0, st_reg.hi_act,
                                             st_reg.lo_act, 3'h0, st_reg.seq};
        default: st_next.rdata = 32'h0;
      endcase
    end
  end

  // State register with documented reset values.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_reg <= '0;
      st_reg.enable <= tlv_pkg::ENABLE_RST;
      st_reg.level <= tlv_pkg::LEVEL_RST;
      st_reg.ext_enable <= tlv_pkg::EXT_RST; // see [RL17]
      st_reg.ext_level <= tlv_pkg::EXT_RST;
      st_reg.irq_stat <= tlv_pkg::EVT_RST;
      st_reg.seq <= tlv_pkg::ST_IDLE;
      st_reg.vector <= tlv_pkg::VEC_RESET;
    end
    else
      st_reg <= st_next;
  end

  // Outputs.
  assign hrdata_o = st_reg.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign call_active_o = (st_reg.seq == tlv_pkg::ST_CALL);
  assign vector_o = st_reg.vector;
  assign vector_taken_o = done_call;
  assign in_service_o = {st_reg.hi_act, st_reg.lo_act};
  assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_call_len;
    @(posedge clk_i) disable iff (!nrst_i)
    take |=> call_active_o [*4] ##1 !call_active_o;
  endproperty
  a_call_len: assert property (p_call_len) else $error("Call did not last four cycles."); // see [RL2]

  property p_vector;
    @(posedge clk_i) disable iff (!nrst_i)
    take |=> (vector_o == 16'h0003 + {9'h000, $past(st_reg.cand_idx), 3'h0}) && vector_o != 16'h006b;
  endproperty
  a_vector: assert property (p_vector) else $error("Wrong vector address."); // see [RL6]

  property p_no_take_on_return;
    @(posedge clk_i) disable iff (!nrst_i)
    return_from_service_now |-> !take;
  endproperty
  a_no_take_on_return: assert property (p_no_take_on_return) else $error("Call at return."); // see [RL3]

  property p_nesting;
    @(posedge clk_i) disable iff (!nrst_i)
    take |-> !st_reg.hi_act && (st_reg.cand_hi || !st_reg.lo_act);
  endproperty
  a_nesting: assert property (p_nesting) else $error("Illegal preemption."); // see [RL15]

  property p_eligible;
    @(posedge clk_i) disable iff (!nrst_i)
    take |-> pending[st_reg.cand_idx] && src_en[st_reg.cand_idx]
             && st_reg.enable[tlv_pkg::GATE_BIT];
  endproperty
  a_eligible: assert property (p_eligible) else $error("Ineligible source vectored."); // see [RL18]

  property p_gate;
    @(posedge clk_i) disable iff (!nrst_i)
    !st_reg.enable[7] |=> !st_reg.cand_valid;
  endproperty
  a_gate: assert property (p_gate) else $error("Request passed closed gate."); // see [RL11]

  property p_auto_clear;
    @(posedge clk_i) disable iff (!nrst_i)
    (done_call && st_reg.call_idx == 4'h1 && !timer_zero_overflow_flag_i && !pend_set[1])
      |=> !local_flags[1];
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("Timer zero flag not cleared."); // see [RL8]

  property p_mask;
    @(posedge clk_i) disable iff (!nrst_i)
    !st_reg.enable[0] |-> !req[0];
  endproperty
  a_mask: assert property (p_mask) else $error("Masked source requested."); // see [RL12]

  property p_irq;
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(st_reg.irq_stat[0]) && st_reg.irq_mask[0] |-> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt output missing.");

endmodule

`default_nettype wire

// ==== include/tlv_pkg.sv ====
/*
  Constants, register map and types of the two-level vectored interrupt controller.
  Assumes a single 100 MHz system clock and a word-aligned 32-bit register bus.
*/
package tlv_pkg;

  // ----------------------------------------------------------------------
  // Sources and vectors
  // ----------------------------------------------------------------------
  localparam int NSRC = 15;
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_TMR0 = 4'h1;
  localparam logic [3:0] SRC_EXT1 = 4'h2;
  localparam logic [3:0] SRC_TMR1 = 4'h3;
  localparam logic [3:0] SRC_RSVD = 4'hd;
  // Sources whose flag is cleared by hardware when the call is made.
  localparam logic [14:0] AUTO_CLR_MASK = 15'h000f;
  // Every slot except the reserved one can raise a request.
  localparam logic [14:0] IMPL_MASK = 15'h5fff;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_STEP_SHIFT = 3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam logic [2:0] CALL_CYCLES = 3'h4;

  // ----------------------------------------------------------------------
  // Register map: printed indices, byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [9:0] ENABLE_IDX = 10'h0a8;
  localparam logic [9:0] LEVEL_IDX = 10'h0b8;
  localparam logic [9:0] EXT_ENABLE_IDX = 10'h0e6;
  localparam logic [9:0] EXT_LEVEL_IDX = 10'h0f6;
  localparam logic [11:0] ENABLE_ADDR = {ENABLE_IDX, 2'h0};
  localparam logic [11:0] LEVEL_ADDR = {LEVEL_IDX, 2'h0};
  localparam logic [11:0] EXT_ENABLE_ADDR = {EXT_ENABLE_IDX, 2'h0};
  localparam logic [11:0] EXT_LEVEL_ADDR = {EXT_LEVEL_IDX, 2'h0};
  localparam logic [11:0] PEND_ADDR = 12'h000;
  localparam logic [11:0] PEND_SET_ADDR = 12'h004;
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h008;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h00c;
  localparam logic [11:0] STATE_ADDR = 12'h010;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int GATE_BIT = 7;
  localparam int EXT_RSVD_BIT = 6;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [6:0] LEVEL_RST = 7'h00;
  localparam logic [7:0] EXT_RST = 8'h00;
  localparam int EVT_VECTORED = 0;
  localparam int EVT_PREEMPT = 1;
  localparam logic [1:0] EVT_RST = 2'h0;

  typedef enum logic [0:0] {ST_IDLE, ST_CALL} tlv_seq_t;

endpackage

// ==== src/tlv_flag_bank.sv ====
/*
  Sticky pending flags held inside the controller.
  Assumes set, clear and hardware-clear inputs are synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module tlv_flag_bank (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Flag controls
  input wire logic [14:0] hw_set_i,
  input wire logic [14:0] sw_set_i,
  input wire logic [14:0] sw_clr_i,
  input wire logic [14:0] hw_clr_i,
  // Flag state
  output logic [14:0] flags_o
);

  typedef struct packed {
    logic [14:0] flags;
  } tlv_fb_state_t;

  tlv_fb_state_t st_reg;
  tlv_fb_state_t st_next;

  // A set in the same cycle as any clear wins, so no event is lost.
  always_comb
  begin
    st_next = st_reg;
    for (int i = 0; i < tlv_pkg::NSRC; i++)
    begin
      if (hw_set_i[i] || sw_set_i[i]) // see [RL14]
        st_next.flags[i] = 1'b1;
      else if (sw_clr_i[i] || hw_clr_i[i])
        st_next.flags[i] = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign flags_o = st_reg.flags;

  property p_sw_set;
    @(posedge clk_i) disable iff (!nrst_i)
    sw_set_i[0] |=> flags_o[0];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("Software set did not raise flag."); // see [RL14]

endmodule

`default_nettype wire

// ==== src/tlv_arbiter.sv ====
/*
  Combinational two-level priority resolver over fifteen request slots.
  Assumes requests are already gated by enables; clock only feeds checks.
*/
`timescale 1ns/1ps
`default_nettype none

module tlv_arbiter (
  // Clock and reset for checks
  input wire logic clk_i,
  input wire logic nrst_i,
  // Requests and levels
  input wire logic [14:0] req_i,
  input wire logic [14:0] hi_i,
  // Winner
  output logic valid_o,
  output logic [3:0] idx_o,
  output logic hi_o
);

  // Lowest slot number of a vector; slot zero ranks first.
  function automatic logic [3:0] first_set(input logic [14:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = tlv_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
        r = 4'(i);
    end
    return r;
  endfunction

  logic [14:0] hi_req;
  logic [14:0] lo_req;

  // High level beats low; fixed order breaks ties inside a level.
  always_comb
  begin
    hi_req = req_i & hi_i;
    lo_req = req_i & ~hi_i;
    valid_o = |req_i;
    hi_o = |hi_req; // see [RL15]
    idx_o = hi_o ? first_set(hi_req) : first_set(lo_req); // see [RL7]
  end

  property p_fixed_order;
    @(posedge clk_i) disable iff (!nrst_i)
    (valid_o && req_i[0] && (hi_i[0] == hi_o)) |-> (idx_o == 4'h0);
  endproperty
  a_fixed_order: assert property (p_fixed_order) else $error("Slot zero lost a tie."); // see [RL7]

  property p_level_first;
    @(posedge clk_i) disable iff (!nrst_i)
    (|(req_i & hi_i)) |-> (hi_o && hi_i[idx_o] && req_i[idx_o]);
  endproperty
  a_level_first: assert property (p_level_first) else $error("Low level won over high."); // see [RL15]

endmodule

`default_nettype wire

// ==== dv/tlv_cpu_model.sv ====
/*
  CPU stand-in that retires instructions and return instructions.
  Assumes the controller's call_active_o stalls instruction retirement.
*/
`timescale 1ns/1ps
`default_nettype none

module tlv_cpu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Controls
  input wire logic call_i,
  input wire logic [3:0] len_i,
  input wire logic ret_i,
  // Retire strobes
  output logic done_o,
  output logic ret_o
);
  logic [3:0] cnt_reg;
  logic pend_reg;

  // A return takes five cycles, any other instruction len_i cycles.
  assign done_o = !call_i && (cnt_reg + 4'h1 >= (pend_reg ? 4'h5 : len_i));
  assign ret_o = done_o && pend_reg;

  // Count cycles; nothing retires while the forced call runs.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_reg <= 4'h0;
      pend_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= (call_i || done_o) ? 4'h0 : cnt_reg + 4'h1;
      pend_reg <= ret_i || (pend_reg && !ret_o);
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb_two_level_vectored_irq_ctrl.sv ====
/*
  Self-checking bench for the vectored interrupt controller.
  Assumes the CPU stand-in model and the design package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_two_level_vectored_irq_ctrl;
  logic clk_i, nrst_i, hsel, hwrite, hrdy, hresp, call, taken, irq, ret, done, rfs;
  logic [1:0] htrans, insvc;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [3:0] len, ext;
  logic [20:0] pf;
  logic [15:0] vec;
  logic [15:0] vq[$];
  logic [14:0] m;
  int fails, compares, seed, n, k;
  localparam int SL[21] = '{4, 4, 5, 5, 6, 6, 6, 6, 7, 8, 9, 10, 11, 11, 11, 11, 11, 12, 12, 14, 14};

  tlv_irq_ctrl dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .ext_request_pin_zero_i(ext[0]),
    .ext_request_pin_one_i(ext[1]), .timer_zero_overflow_flag_i(ext[2]),
    .timer_one_overflow_flag_i(ext[3]), .uart_rx_flag_i(pf[0]), .uart_tx_flag_i(pf[1]),
    .timer_two_high_overflow_i(pf[2]), .timer_two_low_overflow_i(pf[3]),
    .serial_xfer_done_flag_i(pf[4]), .write_collision_flag_i(pf[5]), .mode_fault_flag_i(pf[6]),
    .receive_overrun_flag_i(pf[7]), .smbus_flag_i(pf[8]), .port_match_i(pf[9]),
    .window_compare_flag_i(pf[10]), .conversion_done_flag_i(pf[11]),
    .counter_array_overflow_i(pf[12]), .module_match_flag_i(pf[15:13]),
    .pwm_counter_overflow_i(pf[16]), .comparator_fall_flag_i(pf[17]),
    .comparator_rise_flag_i(pf[18]), .timer_three_high_overflow_i(pf[19]),
    .timer_three_low_overflow_i(pf[20]), .instr_done_i(done), .return_from_service_i(rfs),
    .call_active_o(call), .vector_o(vec), .vector_taken_o(taken), .in_service_o(insvc),
    .irq_o(irq)
  );

  tlv_cpu_model cpu (.clk_i(clk_i), .nrst_i(nrst_i), .call_i(call), .len_i(len), .ret_i(ret),
    .done_o(done), .ret_o(rfs));

  // Clock with a 10 ns period.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Count a comparison and report a mismatch.
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single AHB-Lite transfer; read data is taken at the data phase edge.
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    r = hrdata;
  endtask

  // Register write and checked register read.
  task wr(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk("rd", e, r);
    chk("resp", 32'h0, {31'h0, hresp});
  endtask

  // Retire a return, then let the following instructions run.
  task do_ret;
    @(posedge clk_i);
    ret <= 1'b1;
    @(posedge clk_i);
    ret <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask

  // Bounded wait until only left noted vectors remain.
  task wait_q(input int left);
    n = 0;
    while (vq.size() > left && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    repeat (3) @(posedge clk_i);
  endtask

  // Print the counts and the verdict, then stop.
  task give_verdict;
    chk("left", 32'h0, 32'(vq.size()));
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Each taken strobe consumes the oldest noted vector.
  always @(posedge clk_i)
  begin
    if (taken === 1'b1)
      chk("vec", vq.size() ? {16'h0, vq.pop_front()} : 32'hx, {16'h0, vec});
  end

  // Watchdog against a hang.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    give_verdict();
  end

  // Main sequence.
  initial
  begin
    seed = 32'hd184;
    {hsel, hwrite, ret, htrans, haddr, hwdata, ext, pf} = '0;
    len = 4'h2;
    nrst_i = 1'b0;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    rdc(tlv_pkg::ENABLE_ADDR, 32'h0);
    rdc(tlv_pkg::LEVEL_ADDR, 32'h80);
    rdc(tlv_pkg::EXT_ENABLE_ADDR, 32'h0);
    wr(tlv_pkg::EXT_ENABLE_ADDR, 32'hff);
    rdc(tlv_pkg::EXT_ENABLE_ADDR, 32'hbf);
    wr(12'h100, 32'hff);
    rdc(12'h100, 32'h0);
    // Gate off: random pulses set flags; external zero must wait.
    wr(tlv_pkg::ENABLE_ADDR, 32'h01);
    @(posedge clk_i);
    r = $random(seed);
    ext <= r[3:0] | 4'h1;
    @(posedge clk_i);
    ext <= 4'h0;
    repeat (30) @(posedge clk_i);
    rdc(tlv_pkg::PEND_ADDR, {28'h0, r[3], r[1], r[2], 1'b1});
    wr(tlv_pkg::PEND_ADDR, 32'he);
    vq.push_back(16'h0003);
    wr(tlv_pkg::ENABLE_ADDR, 32'h81);
    wait_q(0);
    rdc(tlv_pkg::PEND_ADDR, 32'h0);
    do_ret();
    // Every peripheral flag maps onto its slot.
    wr(tlv_pkg::ENABLE_ADDR, 32'h0);
    for (int b = 0; b < 21; b++)
    begin
      pf <= 21'h1 << b;
      rdc(tlv_pkg::PEND_ADDR, 32'h1 << SL[b]);
    end
    pf <= 21'h0;
    // Best-case latency, one-cycle instructions; the strobe is seen one edge late.
    wr(tlv_pkg::ENABLE_ADDR, 32'hff);
    wr(tlv_pkg::IRQ_MASK_ADDR, 32'h1);
    len <= 4'h1;
    vq.push_back(16'h002b);
    @(posedge clk_i);
    pf[3] <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (taken !== 1'b1 && n < 50);
    chk("lat", 32'd5, 32'(n - 1));
    pf[3] <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("irq", 32'h1, {31'h0, irq});
    wr(tlv_pkg::IRQ_STAT_ADDR, 32'h3);
    @(posedge clk_i);
    chk("irq", 32'h0, {31'h0, irq});
    do_ret();
    // Each vector alone, then random ties; slot 13 must stay silent.
    for (int i = 0; i < 23; i++)
    begin
      m = (i < 15) ? 15'h1 << i : 15'($random(seed)) & tlv_pkg::IMPL_MASK;
      if (m == 15'h0)
        continue;
      len <= 4'h1 + 4'($random(seed) & 7);
      k = 0;
      while (!m[k])
        k++;
      if (k != 13)
        vq.push_back(tlv_pkg::VEC_BASE + 16'(k * 8));
      wr(tlv_pkg::PEND_SET_ADDR, {17'h0, m});
      wait_q(0);
      wr(tlv_pkg::PEND_ADDR, 32'h7fff);
      do_ret();
    end
    // High level first; low waits for the return and one instruction.
    wr(tlv_pkg::LEVEL_ADDR, 32'h40);
    vq.push_back(16'h0033);
    vq.push_back(16'h0003);
    wr(tlv_pkg::PEND_SET_ADDR, 32'h41);
    wait_q(1);
    wr(tlv_pkg::PEND_ADDR, 32'h40);
    do_ret();
    wait_q(0);
    do_ret();
    // A high request preempts a running low routine.
    wr(tlv_pkg::IRQ_MASK_ADDR, 32'h3);
    vq.push_back(16'h000b);
    wr(tlv_pkg::PEND_SET_ADDR, 32'h2);
    wait_q(0);
    wr(tlv_pkg::IRQ_STAT_ADDR, 32'h3);
    vq.push_back(16'h0033);
    wr(tlv_pkg::PEND_SET_ADDR, 32'h40);
    wait_q(0);
    rdc(tlv_pkg::IRQ_STAT_ADDR, 32'h3);
    chk("svc", 32'h3, {30'h0, insvc});
    chk("irq", 32'h1, {31'h0, irq});
    wr(tlv_pkg::IRQ_MASK_ADDR, 32'h0);
    @(posedge clk_i);
    chk("irq", 32'h0, {31'h0, irq});
    wr(tlv_pkg::PEND_ADDR, 32'h40);
    do_ret();
    do_ret();
    chk("svc", 32'h0, {30'h0, insvc});
    give_verdict();
  end
endmodule
`default_nettype wire
